// *** core/cca_consts.vh ***
// offsets, field positions and reset values of the counter array
`ifndef CCA_CONSTS_VH
`define CCA_CONSTS_VH
// register offsets (5-bit address)
`define CCA_ADDR_CTRL      5'h00
`define CCA_ADDR_MODE      5'h01
`define CCA_ADDR_CNT_LO    5'h02
`define CCA_ADDR_CNT_HI    5'h03
`define CCA_ADDR_MMODE0    5'h04
`define CCA_ADDR_CC_LO0    5'h08
`define CCA_NUM_MODULES    3
// array_control_reg fields
`define CCA_CTRL_CF        7
`define CCA_CTRL_RUN       6
// array_mode_reg fields
`define CCA_MODE_IDLE      7
`define CCA_MODE_WDE       6
`define CCA_MODE_WDLOCK    5
`define CCA_MODE_TB_HI     3
`define CCA_MODE_TB_LO     1
`define CCA_MODE_OVF_IE    0
`define CCA_MODE_RESET     8'h40
// module_mode_reg fields
`define CCA_MM_WIDE        7
`define CCA_MM_CMP         6
`define CCA_MM_RISE        5
`define CCA_MM_FALL        4
`define CCA_MM_MATCH       3
`define CCA_MM_TOG         2
`define CCA_MM_PULSE       1
`define CCA_MM_IRQ         0
// timebase_select codes
`define CCA_TB_DIV12       3'h0
`define CCA_TB_DIV4        3'h1
`define CCA_TB_T0          3'h2
`define CCA_TB_EXT         3'h3
`define CCA_TB_SYS         3'h4
`define CCA_TB_OSC8        3'h5
// prescaler terminal counts
`define CCA_PRE_LAST       4'hb
`define CCA_OSC_LAST       3'h7
`endif

// *** core/cca_counter_array.v ***
// counter array: 16-bit timebase counter and three capture/compare modules
//
// Implementation choices: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "cca_consts.vh"

module cca_counter_array (
   input  wire       clock,
   input  wire       rst_n,
   input  wire [4:0] reg_addr,
   input  wire [7:0] reg_wdata,
   input  wire       reg_wr,
   input  wire       reg_rd,
   output reg  [7:0] reg_rdata,
   input  wire       global_irq_enable,
   input  wire       array_irq_enable,
   input  wire       cpu_idle,
   input  wire       timer0_overflow,
   input  wire       external_count_input,
   input  wire       ext_osc_clk,
   input  wire [2:0] module_io_in,
   output reg  [2:0] module_io_out,
   output reg  [2:0] module_io_oe,
   output reg        irq_req
);

   // register state
   reg  [15:0] count_reg;
   reg  [7:0]  snap_reg;
   reg  [7:0]  mode_reg;
   reg         run_reg;
   reg         cf_reg;
   reg  [2:0]  mef_reg;
   reg  [7:0]  mm_reg [0:2];
   reg  [15:0] cc_reg [0:2];
   reg  [3:0]  pre_reg;
   reg  [2:0]  osc_cnt_reg;
   reg  [2:0]  hso_prev_reg;
   // synchronisers: three stages, change taken when stages two and three agree
   reg  [2:0]  eci_sync_reg;
   reg         eci_lvl_reg;
   reg  [2:0]  osc_sync_reg;
   reg         osc_lvl_reg;
   reg  [2:0]  io_s1_reg;
   reg  [2:0]  io_s2_reg;
   reg  [2:0]  io_s3_reg;
   reg  [2:0]  io_lvl_reg;

   wire        wd_on = mode_reg[`CCA_MODE_WDE] | mode_reg[`CCA_MODE_WDLOCK];
   wire [2:0]  tb_sel = mode_reg[`CCA_MODE_TB_HI:`CCA_MODE_TB_LO];

   // decode helpers used by every module
   function is_capture;
      input [7:0] mm;
      begin
         is_capture = (mm[`CCA_MM_RISE] | mm[`CCA_MM_FALL]) &
                      ~mm[`CCA_MM_MATCH] & ~mm[`CCA_MM_TOG] & ~mm[`CCA_MM_PULSE];
      end
   endfunction

   function is_timer;
      input [7:0] mm;
      begin
         is_timer = mm[`CCA_MM_CMP] & ~mm[`CCA_MM_RISE] & ~mm[`CCA_MM_FALL] &
                    mm[`CCA_MM_MATCH] & ~mm[`CCA_MM_TOG] & ~mm[`CCA_MM_PULSE];
      end
   endfunction

   function is_hso;
      input [7:0] mm;
      begin
         is_hso = mm[`CCA_MM_CMP] & ~mm[`CCA_MM_RISE] & ~mm[`CCA_MM_FALL] &
                  mm[`CCA_MM_MATCH] & mm[`CCA_MM_TOG] & ~mm[`CCA_MM_PULSE];
      end
   endfunction

   // frequency and pwm decodes feed only the unused pwm_modes wire;
   // their waveform generation is not built in this block
   function [1:0] pwm_kind;
      input [7:0] mm;
      reg         base;
      begin
         base = mm[`CCA_MM_CMP] & ~mm[`CCA_MM_RISE] & ~mm[`CCA_MM_FALL];
         pwm_kind = 2'h0;
         if (base & mm[`CCA_MM_TOG] & mm[`CCA_MM_PULSE]) begin
            pwm_kind = 2'h1;                                  // frequency
         end else if (base & ~mm[`CCA_MM_TOG] & mm[`CCA_MM_PULSE]) begin
            pwm_kind = mm[`CCA_MM_WIDE] ? 2'h3 : 2'h2;        // 16/8-bit pwm
         end
      end
   endfunction

   // synchronised edges of the pin inputs; the oscillator passes through the same synchroniser,
   // so it must stay below a quarter of the clock rate for every edge to be seen
   wire       eci_stable = (eci_sync_reg[1] == eci_sync_reg[2]);
   wire       eci_fall   = eci_stable & eci_lvl_reg & ~eci_sync_reg[2];
   wire       osc_stable = (osc_sync_reg[1] == osc_sync_reg[2]);
   wire       osc_rise   = osc_stable & ~osc_lvl_reg & osc_sync_reg[2];
   wire [2:0] io_stable  = ~(io_s2_reg ^ io_s3_reg);
   wire [2:0] io_rise    = io_stable & ~io_lvl_reg & io_s3_reg;
   wire [2:0] io_fall    = io_stable & io_lvl_reg & ~io_s3_reg;

   // timebase event selection
   reg tb_tick;
   always @* begin
      case (tb_sel)
         `CCA_TB_DIV12: tb_tick = (pre_reg == `CCA_PRE_LAST);
         `CCA_TB_DIV4:  tb_tick = (pre_reg[1:0] == 2'h3);
         `CCA_TB_T0:    tb_tick = timer0_overflow;
         `CCA_TB_EXT:   tb_tick = eci_fall;
         `CCA_TB_SYS:   tb_tick = 1'b1;
         `CCA_TB_OSC8:  tb_tick = osc_rise &
                                  (osc_cnt_reg == `CCA_OSC_LAST);
         default:       tb_tick = 1'b0;
      endcase
   end

   // watchdog forces the counter on; idle may suspend it
   // the watchdog reset itself is not generated in this block
   wire running = (run_reg | wd_on) &
                  ~(cpu_idle & mode_reg[`CCA_MODE_IDLE]);
   wire step    = running & tb_tick;
   wire [15:0] count_inc = count_reg + 16'h0001;
   wire        wrap      = step & (count_reg == 16'hffff);

   // register write decode
   wire wr_ctrl  = reg_wr & (reg_addr == `CCA_ADDR_CTRL);
   wire wr_mode  = reg_wr & (reg_addr == `CCA_ADDR_MODE);
   wire wr_cnt_l = reg_wr & (reg_addr == `CCA_ADDR_CNT_LO) & ~wd_on;
   wire wr_cnt_h = reg_wr & (reg_addr == `CCA_ADDR_CNT_HI) & ~wd_on;

   // per-module write strobes, each address decoded in one place
   function [4:0] cc_addr;
      input [1:0] idx;
      input       hi;
      begin
         cc_addr = `CCA_ADDR_CC_LO0 + {2'h0, idx, hi};
      end
   endfunction

   reg [2:0] wr_mm;
   reg [2:0] wr_cc_lo;
   reg [2:0] wr_cc_hi;
   integer   w;
   always @* begin
      wr_mm    = 3'h0;
      wr_cc_lo = 3'h0;
      wr_cc_hi = 3'h0;
      for (w = 0; w < `CCA_NUM_MODULES; w = w + 1) begin
         // module 2 mode is locked while the watchdog owns it
         wr_mm[w]    = reg_wr & (reg_addr == `CCA_ADDR_MMODE0 + w[4:0]) &
                       ~(wd_on & (w == 2));
         wr_cc_lo[w] = reg_wr & (reg_addr == cc_addr(w[1:0], 1'b0));
         wr_cc_hi[w] = reg_wr & (reg_addr == cc_addr(w[1:0], 1'b1));
      end
   end

   // per-module events, compared with the stepped count
   reg [2:0] ev_set;
   reg [2:0] cap_hit;
   reg [2:0] cmp_hit;
   integer   i;
   always @* begin
      ev_set  = 3'h0;
      cap_hit = 3'h0;
      cmp_hit = 3'h0;
      for (i = 0; i < `CCA_NUM_MODULES; i = i + 1) begin
         cap_hit[i] = is_capture(mm_reg[i]) &
                      ((mm_reg[i][`CCA_MM_RISE] & io_rise[i]) |
                       (mm_reg[i][`CCA_MM_FALL] & io_fall[i]));
         cmp_hit[i] = step & (count_inc == cc_reg[i]) &
                      (is_timer(mm_reg[i]) | is_hso(mm_reg[i]));
         ev_set[i]  = cap_hit[i] | (cmp_hit[i] & is_timer(mm_reg[i]));
      end
   end

   // pin synchronisers and prescalers
   always @(posedge clock) begin
      if (!rst_n) begin
         eci_sync_reg <= 3'h7;
         eci_lvl_reg  <= 1'b1;
         osc_sync_reg <= 3'h0;
         osc_lvl_reg  <= 1'b0;
         io_s1_reg    <= 3'h0;
         io_s2_reg    <= 3'h0;
         io_s3_reg    <= 3'h0;
         io_lvl_reg   <= 3'h0;
         pre_reg      <= 4'h0;
         osc_cnt_reg  <= 3'h0;
      end else begin
         eci_sync_reg <= {eci_sync_reg[1:0], external_count_input};
         osc_sync_reg <= {osc_sync_reg[1:0], ext_osc_clk};
         io_s1_reg    <= module_io_in;
         io_s2_reg    <= io_s1_reg;
         io_s3_reg    <= io_s2_reg;
         if (eci_stable) begin
            eci_lvl_reg <= eci_sync_reg[2];
         end
         if (osc_stable) begin
            osc_lvl_reg <= osc_sync_reg[2];
         end
         io_lvl_reg <= (io_lvl_reg & ~io_stable) | (io_s3_reg & io_stable);
         // shared prescaler: divide by 12, with every fourth count a /4 tick
         pre_reg <= (pre_reg == `CCA_PRE_LAST) ? 4'h0 : pre_reg + 4'h1;
         if (osc_rise) begin
            osc_cnt_reg <= osc_cnt_reg + 3'h1;
         end
      end
   end

   // counter, snapshot and array control/mode registers
   always @(posedge clock) begin
      if (!rst_n) begin
         count_reg <= 16'h0000;
         snap_reg  <= 8'h00;
         mode_reg  <= `CCA_MODE_RESET;
         run_reg   <= 1'b0;
         cf_reg    <= 1'b0;
      end else begin
         if (wr_cnt_l) begin
            count_reg[7:0] <= reg_wdata;
         end else if (wr_cnt_h) begin
            count_reg[15:8] <= reg_wdata;
         end else if (step) begin
            count_reg <= count_inc;
         end
         if (reg_rd && reg_addr == `CCA_ADDR_CNT_LO) begin
            snap_reg <= count_reg[15:8];
         end
         if (wr_ctrl) begin
            run_reg <= reg_wdata[`CCA_CTRL_RUN];
         end
         // a wrap in the same cycle as the clearing write wins
         if (wrap) begin
            cf_reg <= 1'b1;
         end else if (wr_ctrl) begin
            cf_reg <= reg_wdata[`CCA_CTRL_CF];
         end
         if (wr_mode) begin
            mode_reg[`CCA_MODE_OVF_IE] <= reg_wdata[`CCA_MODE_OVF_IE];
            // lock holds the watchdog until the next reset
            mode_reg[`CCA_MODE_WDE] <= reg_wdata[`CCA_MODE_WDE] |
                                       mode_reg[`CCA_MODE_WDLOCK];
            mode_reg[`CCA_MODE_WDLOCK] <= reg_wdata[`CCA_MODE_WDLOCK] |
                                          mode_reg[`CCA_MODE_WDLOCK];
            if (!wd_on) begin
               mode_reg[`CCA_MODE_TB_HI:`CCA_MODE_TB_LO] <=
                  reg_wdata[`CCA_MODE_TB_HI:`CCA_MODE_TB_LO];
               mode_reg[`CCA_MODE_IDLE] <= reg_wdata[`CCA_MODE_IDLE];
            end
         end
      end
   end

   // module registers, flags and toggle outputs
   integer m;
   always @(posedge clock) begin
      if (!rst_n) begin
         mef_reg       <= 3'h0;
         hso_prev_reg  <= 3'h0;
         module_io_out <= 3'h0;
         module_io_oe  <= 3'h0;
         for (m = 0; m < `CCA_NUM_MODULES; m = m + 1) begin
            mm_reg[m] <= 8'h00;
            cc_reg[m] <= 16'h0000;
         end
      end else begin
         for (m = 0; m < `CCA_NUM_MODULES; m = m + 1) begin
            // set wins over a clearing write in the same cycle
            if (ev_set[m]) begin
               mef_reg[m] <= 1'b1;
            end else if (wr_ctrl) begin
               mef_reg[m] <= reg_wdata[m];
            end
            if (wr_mm[m]) begin
               mm_reg[m] <= reg_wdata;
            end else if (wr_cc_lo[m]) begin
               mm_reg[m][`CCA_MM_CMP] <= 1'b0;
            end else if (wr_cc_hi[m]) begin
               mm_reg[m][`CCA_MM_CMP] <= 1'b1;
            end
            // a capture wins over a software byte write
            if (cap_hit[m]) begin
               cc_reg[m] <= count_reg;
            end else if (wr_cc_lo[m]) begin
               cc_reg[m][7:0] <= reg_wdata;
            end else if (wr_cc_hi[m]) begin
               cc_reg[m][15:8] <= reg_wdata;
            end
            hso_prev_reg[m] <= is_hso(mm_reg[m]);
            module_io_oe[m] <= is_hso(mm_reg[m]);
            if (is_hso(mm_reg[m]) && !hso_prev_reg[m]) begin
               module_io_out[m] <= 1'b1;
            end else if (is_hso(mm_reg[m]) && cmp_hit[m]) begin
               module_io_out[m] <= ~module_io_out[m];
            end
         end
      end
   end

   // interrupt request gating
   // trails the flags by one cycle so the pin comes from a flip-flop
   wire [2:0] mod_ie = {mm_reg[2][`CCA_MM_IRQ], mm_reg[1][`CCA_MM_IRQ],
                        mm_reg[0][`CCA_MM_IRQ]};
   always @(posedge clock) begin
      if (!rst_n) begin
         irq_req <= 1'b0;
      end else begin
         irq_req <= global_irq_enable & array_irq_enable &
                    ((cf_reg & mode_reg[`CCA_MODE_OVF_IE]) | (|(mef_reg & mod_ie)));
      end
   end

   // read data, one cycle after the strobe; unmapped reads give zero
   reg [7:0] rd_mux;
   always @* begin
      rd_mux = 8'h00;
      if (reg_addr == `CCA_ADDR_CTRL) begin
         rd_mux = {cf_reg, run_reg, 3'h0, mef_reg};
      end else if (reg_addr == `CCA_ADDR_MODE) begin
         rd_mux = mode_reg;
      end else if (reg_addr == `CCA_ADDR_CNT_LO) begin
         rd_mux = count_reg[7:0];
      end else if (reg_addr == `CCA_ADDR_CNT_HI) begin
         rd_mux = snap_reg;
      end else if (reg_addr >= `CCA_ADDR_MMODE0 && reg_addr < `CCA_ADDR_MMODE0 + 5'h3) begin
         rd_mux = mm_reg[reg_addr[1:0]];
      end else if (reg_addr >= `CCA_ADDR_CC_LO0 && reg_addr < `CCA_ADDR_CC_LO0 + 5'h6) begin
         rd_mux = reg_addr[0] ? cc_reg[reg_addr[2:1]][15:8]
                              : cc_reg[reg_addr[2:1]][7:0];
      end
   end

   always @(posedge clock) begin
      if (!rst_n) begin
         reg_rdata <= 8'h00;
      end else begin
         reg_rdata <= reg_rd ? rd_mux : 8'h00;
      end
   end

   // unused decode, not connected to the mode register readback path
   wire [5:0] pwm_modes = {pwm_kind(mm_reg[2]), pwm_kind(mm_reg[1]), pwm_kind(mm_reg[0])};

endmodule // cca_counter_array
`default_nettype wire

// *** tb/cca_asserts.sv ***
// port checker for the counter array, bound into the design
`timescale 1ns/1ps
`default_nettype none
module cca_asserts (
   input wire logic       clock,
   input wire logic       rst_n,
   input wire logic [4:0] reg_addr,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic       global_irq_enable,
   input wire logic       array_irq_enable,
   input wire logic [2:0] module_io_out,
   input wire logic [2:0] module_io_oe,
   input wire logic       irq_req
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   // read data stand only in the answer cycle
   a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data outside the answer cycle");
   a_unmapped_zero: assert property (
      reg_rd && reg_addr == 5'h1f |=> reg_rdata == 8'h00)
      else $error("unmapped read returned data");
   // reset itself is watched here, so no disable
   a_reset_quiet: assert property (disable iff (1'b0)
      !rst_n |=> reg_rdata == 8'h00 && !irq_req && module_io_oe == 3'h0)
      else $error("outputs not quiet after reset");
   a_irq_gated: assert property (
      irq_req |-> $past(global_irq_enable) && $past(array_irq_enable))
      else $error("request without both enables");
   // flags fall only through software, so must the request
   a_irq_clear_cause: assert property ($fell(irq_req) |->
      $past(reg_wr) || $past(reg_wr, 2) || !$past(global_irq_enable) || !$past(array_irq_enable))
      else $error("request dropped without cause");
   a_oe_by_software: assert property (
      $changed(module_io_oe) |-> $past(reg_wr) || $past(reg_wr, 2))
      else $error("output mode changed without a write");
   a_hso_starts_one: assert property ($rose(module_io_oe[1]) |-> module_io_out[1])
      else $error("toggle output not one on entry");
   a_out_quiet: assert property (
      !module_io_oe[1] && !$past(module_io_oe[1]) && !$past(module_io_oe[1], 2)
      |-> $stable(module_io_out[1]))
      else $error("output moved outside high-speed mode");
endmodule // cca_asserts
bind cca_counter_array cca_asserts u_asserts (.clock, .rst_n, .reg_addr, .reg_wr, .reg_rd,
   .reg_rdata, .global_irq_enable, .array_irq_enable, .module_io_out, .module_io_oe, .irq_req);
`default_nettype wire

// *** tb/cca_pin_model.sv ***
// far side model: module pins and count input with minimum hold times
`timescale 1ns/1ps
`default_nettype none
module cca_pin_model (
   input  wire logic       clock,
   input  wire logic [3:0] want,
   input  wire logic [2:0] module_io_out,
   input  wire logic [2:0] module_io_oe,
   output wire logic [2:0] module_io_in,
   output wire logic       external_count_input
);
   logic [3:0] level_reg = 4'h8; // count input idles high
   int         hold = 0;
   // a level moves only after four clocks, slower than the pins allow
   always @(posedge clock) begin
      hold <= hold + 1;
      if (want != level_reg && hold >= 3) begin
         level_reg <= want;
         hold <= 0;
      end
   end
   // a pin the module drives reads back its own level
   assign module_io_in = (module_io_oe & module_io_out) | (~module_io_oe & level_reg[2:0]);
   assign external_count_input = level_reg[3];
endmodule // cca_pin_model
`default_nettype wire

// *** tb/counter_array_capture_compare_bench.sv ***
// self-checking bench for the counter array
`timescale 1ns/1ps
`default_nettype none
`include "cca_consts.vh"
module counter_array_capture_compare_bench;
   logic       clock = 1'b0;
   logic       rst_n = 1'b0;
   logic [4:0] reg_addr = 5'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic       reg_wr = 1'b0;
   logic       reg_rd = 1'b0;
   logic       global_irq_enable = 1'b0;
   logic       array_irq_enable = 1'b0;
   logic       cpu_idle = 1'b0;
   logic       timer0_overflow = 1'b0;
   logic       ext_osc_clk = 1'b0;
   logic [3:0] want = 4'h8;
   logic [7:0] reg_rdata, q, lo;
   logic [2:0] module_io_in, module_io_out, module_io_oe;
   logic       external_count_input, irq_req;
   int         errors = 0;
   int         n_checks = 0;
   int         r;
   cca_counter_array u_dut (.clock, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata, .global_irq_enable, .array_irq_enable, .cpu_idle, .timer0_overflow,
      .external_count_input, .ext_osc_clk, .module_io_in, .module_io_out, .module_io_oe,
      .irq_req);
   cca_pin_model u_pins (.clock, .want, .module_io_out, .module_io_oe, .module_io_in,
      .external_count_input);
   initial forever #5 clock = ~clock;
   // hang guard
   initial begin
      #500000;
      errors++;
      conclude;
   end
   task automatic conclude;
      if (errors == 0 && n_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   // one transfer, then an idle cycle so strobes never reassign at one edge
   task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
      reg_wr <= w;
      reg_rd <= !w;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clock);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      #1 q = reg_rdata;
      @(posedge clock);
   endtask
   task automatic chk_cnt(input logic [15:0] e);
      bus(1'b0, `CCA_ADDR_CNT_LO, 8'h00);
      lo = q;
      bus(1'b0, `CCA_ADDR_CNT_HI, 8'h00);
      check(lo, e[7:0]);
      check(q, e[15:8]);
   endtask
   task automatic irq_is(input logic e);
      int k;
      k = 0;
      #1;
      while (irq_req !== e && k < 10) begin
         @(posedge clock);
         #1;
         k++;
      end
      check({7'h00, irq_req}, {7'h00, e});
      @(posedge clock);
   endtask
   // stopped load, run window of n clocks (kind 0) or n events, stop and compare with the model count
   task automatic run_tb(input logic [7:0] md, input int kind, input int n,
                         input logic [15:0] start, input logic [15:0] e);
      bus(1'b1, `CCA_ADDR_MODE, md);
      bus(1'b1, `CCA_ADDR_CNT_LO, start[7:0]);
      bus(1'b1, `CCA_ADDR_CNT_HI, start[15:8]);
      bus(1'b1, `CCA_ADDR_CTRL, 8'h40);
      if (kind == 0) begin
         // a read inside the window must not disturb the count
         bus(1'b0, `CCA_ADDR_CNT_LO, 8'h00);
         repeat (n - 6) @(posedge clock);
      end else begin
         repeat (n) begin
            if (kind == 1) begin
               timer0_overflow <= 1'b1;
               @(posedge clock);
               timer0_overflow <= 1'b0;
               repeat (2) @(posedge clock);
            end else if (kind == 2) begin
               want[3] <= 1'b1;
               repeat (6) @(posedge clock);
               want[3] <= 1'b0;
               repeat (6) @(posedge clock);
            end else
               repeat (8) begin
                  #25 ext_osc_clk = 1'b1;
                  #25 ext_osc_clk = 1'b0;
               end
         end
         repeat (12) @(posedge clock);
      end
      // stop by writing the flags back, so events of the window survive
      bus(1'b0, `CCA_ADDR_CTRL, 8'h00);
      bus(1'b1, `CCA_ADDR_CTRL, q & 8'h87);
      chk_cnt(e);
   endtask
   initial begin
      void'($urandom(32'hb2bf));
      repeat (4) @(posedge clock);
      rst_n <= 1'b1;
      global_irq_enable <= 1'b1;
      array_irq_enable <= 1'b1;
      @(posedge clock);
      bus(1'b0, `CCA_ADDR_MODE, 8'h00);
      check(q, `CCA_MODE_RESET);
      bus(1'b1, `CCA_ADDR_MODE, 8'h4a);
      bus(1'b0, `CCA_ADDR_MODE, 8'h00);
      check(q, 8'h40);
      bus(1'b0, 5'h1f, 8'h00);
      check(q, 8'h00);
      // every timebase code, windows chosen as whole prescaler periods
      run_tb(8'h00, 0, 120, 16'h0000, 16'h000a);
      run_tb(8'h02, 0, 48, 16'h0000, 16'h000c);
      run_tb(8'h08, 0, 40, 16'h0000, 16'h0028);
      r = 1 + $urandom % 8;
      run_tb(8'h04, 1, r, 16'h0000, 16'(r));
      r = 1 + $urandom % 8;
      run_tb(8'h06, 2, r, 16'h0000, 16'(r));
      r = 1 + $urandom % 8;
      run_tb(8'h0a, 3, r, 16'h0000, 16'(r));
      cpu_idle <= 1'b1;
      run_tb(8'h88, 0, 40, 16'h0000, 16'h0000);
      run_tb(8'h08, 0, 40, 16'h0000, 16'h0028);
      cpu_idle <= 1'b0;
      // snapshot outlives a later high byte write
      bus(1'b0, `CCA_ADDR_CNT_LO, 8'h00);
      bus(1'b1, `CCA_ADDR_CNT_HI, 8'h77);
      bus(1'b0, `CCA_ADDR_CNT_HI, 8'h00);
      check(q, 8'h00);
      run_tb(8'h09, 0, 20, 16'hfff0, 16'h0004);
      bus(1'b0, `CCA_ADDR_CTRL, 8'h00);
      check(q & 8'h80, 8'h80);
      irq_is(1'b1);
      array_irq_enable <= 1'b0;
      irq_is(1'b0);
      array_irq_enable <= 1'b1;
      irq_is(1'b1);
      bus(1'b1, `CCA_ADDR_CTRL, 8'h00);
      irq_is(1'b0);
      // capture on rise, fall and both, one module each, counter stopped
      for (int i = 0; i < 3; i++) begin
         bus(1'b1, 5'(`CCA_ADDR_MMODE0 + i), (i == 0) ? 8'h20 : (i == 1) ? 8'h10 : 8'h30);
         bus(1'b1, `CCA_ADDR_CNT_LO, 8'(i));
         bus(1'b1, `CCA_ADDR_CNT_HI, 8'h11);
         want[i] <= 1'b1;
         repeat (10) @(posedge clock);
         bus(1'b1, `CCA_ADDR_CNT_HI, 8'h22);
         want[i] <= 1'b0;
         repeat (10) @(posedge clock);
         bus(1'b0, `CCA_ADDR_CTRL, 8'h00);
         check(q & (8'h01 << i), 8'h01 << i);
         bus(1'b0, 5'(`CCA_ADDR_CC_LO0 + 2 * i + 1), 8'h00);
         check(q, (i == 0) ? 8'h11 : 8'h22);
         bus(1'b0, 5'(`CCA_ADDR_CC_LO0 + 2 * i), 8'h00);
         check(q, 8'(i));
      end
      // software timer on module 0 with its request enabled
      bus(1'b1, `CCA_ADDR_CTRL, 8'h00);
      bus(1'b1, `CCA_ADDR_MMODE0, 8'h49);
      bus(1'b1, `CCA_ADDR_CC_LO0, 8'h10);
      bus(1'b0, `CCA_ADDR_MMODE0, 8'h00);
      check(q, 8'h09);
      bus(1'b1, `CCA_ADDR_CC_LO0 + 5'h01, 8'h00);
      bus(1'b0, `CCA_ADDR_MMODE0, 8'h00);
      check(q, 8'h49);
      run_tb(8'h08, 0, 20, 16'h0000, 16'h0014);
      bus(1'b0, `CCA_ADDR_CTRL, 8'h00);
      check(q & 8'h01, 8'h01);
      irq_is(1'b1);
      // high-speed output on module 1, one match in the window
      bus(1'b1, `CCA_ADDR_MMODE0 + 5'h01, 8'h4c);
      bus(1'b1, `CCA_ADDR_CC_LO0 + 5'h02, 8'h08);
      bus(1'b1, `CCA_ADDR_CC_LO0 + 5'h03, 8'h00);
      #1 check({6'h00, module_io_oe[1], module_io_out[1]}, 8'h03);
      @(posedge clock);
      run_tb(8'h08, 0, 20, 16'h0000, 16'h0014);
      check({7'h00, module_io_out[1]}, 8'h00);
      conclude;
   end
endmodule // counter_array_capture_compare_bench
`default_nettype wire
